// [rtl/bfe_pkg.sv]
// Constants and types shared by the event counting block
package bfe_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [4:0] OFS_SEL0  = 5'h00;
    localparam logic [4:0] OFS_SEL1  = 5'h04;
    localparam logic [4:0] OFS_CTR0  = 5'h08;
    localparam logic [4:0] OFS_CTR1  = 5'h0C;
    localparam logic [4:0] OFS_STS   = 5'h10;
    localparam logic [4:0] OFS_IEN   = 5'h14;
    localparam logic [4:0] OFS_ICLR  = 5'h18;
    localparam logic [4:0] OFS_RATIO = 5'h1C;

    // ==========================================================
    // Event select fields
    localparam int SEL_EVT_LSB = 0;
    localparam int SEL_UM_LSB  = 8;
    localparam int SEL_PC_BIT  = 19;
    localparam int SEL_EN_BIT  = 22;

    // ==========================================================
    // Event codes and unit masks
    localparam logic [7:0] EVT_MEM   = 8'h6F;
    localparam logic [7:0] EVT_RCV   = 8'h64;
    localparam logic [7:0] EVT_BNR   = 8'h61;
    localparam logic [7:0] EVT_HIT   = 8'h7A;
    localparam logic [7:0] EVT_MODIFIED_HIT_PIN  = 8'h7B;
    localparam logic [7:0] EVT_STALL = 8'h7E;
    localparam logic [7:0] EVT_FP_RETIRED_EVENT = 8'hC1;
    localparam logic [7:0] EVT_FPEXE = 8'h10;
    localparam logic [7:0] UM_SELF   = 8'h00;
    localparam logic [7:0] UM_ANY    = 8'h20;

    // ==========================================================
    // Core-to-bus ratio strap codes
    localparam logic [2:0] RATIO_2TO1 = 3'h1;
    localparam logic [2:0] RATIO_3TO1 = 3'h2;

    // ==========================================================
    // Reset values and limits
    localparam logic [31:0] SEL_RST   = 32'h0000_0000;
    localparam logic [31:0] CTR_RST   = 32'h0000_0000;
    localparam logic [31:0] CTR_MAX   = 32'hFFFF_FFFF;
    localparam logic [1:0]  FLAGS_RST = 2'h0;
    localparam logic [2:0]  RATIO_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic        IRQ_RST   = 1'b0;

    // ==========================================================
    // Qualified event occurrences in one core cycle
    typedef struct packed {
        logic mem_self;
        logic mem_any;
        logic rcv;
        logic bnr;
        logic hit;
        logic modified_hit_pin;
        logic stall;
        logic fp_retired_event;
        logic fpexe;
    } bfe_ev_t;

endpackage

// [rtl/bfe_sync.sv]
// Two flip-flop synchroniser for pin levels
module bfe_sync #(
    parameter int W = 3
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import bfe_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bfe_sync_st_t;

    bfe_sync_st_t st_ff;
    bfe_sync_st_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.s2;
endmodule

// [rtl/bfe_bpm_pin.sv]
// One breakpoint-monitor pin driven by counter overflow
module bfe_bpm_pin (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ovf,
    input  wire logic pin_control_bit,
    input  wire logic gate,
    output logic      pin
);
    import bfe_pkg::*;

    typedef struct packed {
        logic pin;
    } bfe_bpm_st_t;

    bfe_bpm_st_t st_ff;
    bfe_bpm_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!gate) begin
            // Ratio unsupported: pin holds, no indication
            nxt_st.pin = st_ff.pin;
        end else if (pin_control_bit) begin
            nxt_st.pin = ovf;
        end else if (ovf) begin
            nxt_st.pin = ~st_ff.pin;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin = st_ff.pin;
endmodule

// [rtl/bfe_event_counting.sv]
// Bus and floating-point event qualification with two counters
// Operation
// - code 6FH counts completed memory transactions, own (00H) or any (20H).
// - code 64H counts bus cycles in which this agent receives data.
// - code 61H counts bus cycles in which the throttle pin is driven.
// - code 7AH counts bus cycles driving snoop hit, stalls included.
// - code 7BH counts bus cycles driving modified hit, stalls included.
// - hit events, ratio 2:1 or 3:1, bit 19 set: monitor pin pulses.
// - hit events, bit 19 clear: monitor pin toggles on each overflow.
// - hit events at other ratios: no pin indication, counting still correct.
// - code 7EH counts clock cycles the bus is snoop stalled.
// - code C1H counts retired FP computational ops, counter 0 only.
// - retired count drops traps, assists, loads, stores; keeps assist-run ops.
// - code 10H counts executed FP computational ops, counter 0 only.
module bfe_event_counting (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        bus_tick,
    input  wire logic        mem_tran_done,
    input  wire logic        mem_tran_own,
    input  wire logic        data_rcv_active,
    input  wire logic        throttle_drive,
    input  wire logic        hit_drive,
    input  wire logic        modified_hit_pin_drive,
    input  wire logic        snoop_stall,
    input  wire logic        fp_retire_valid,
    input  wire logic        fp_retire_trap,
    input  wire logic        fp_retire_assist,
    input  wire logic        fp_retire_ldst,
    input  wire logic        fp_exec_valid,
    input  wire logic [2:0]  clk_ratio_pin,
    output logic      [1:0]  breakpoint_monitor_pins,
    output logic             irq
);
    import bfe_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] event_select_zero;
        logic [31:0] event_select_one;
        logic [31:0] ctr0;
        logic [31:0] ctr1;
        logic [1:0]  sts;
        logic [1:0]  ien;
        logic [31:0] rdata;
        logic        irq;
        logic [1:0]  ovf;
    } bfe_st_t;

    bfe_st_t     st_ff;
    bfe_st_t     nxt_st;
    bfe_ev_t     ev;
    logic [2:0]  ratio_sync;
    logic        ratio_ok;
    logic        inc0;
    logic        inc1;
    logic [1:0]  bpm_gate;
    logic [32:0] step0;
    logic [32:0] step1;
    logic        fp_clean;
    logic [1:0]  clr_mask;

    // ==========================================================
    // Functions
    function automatic logic [7:0] sel_code(input logic [31:0] sel);
        return sel[SEL_EVT_LSB +: 8];
    endfunction

    function automatic logic [7:0] sel_umask(input logic [31:0] sel);
        return sel[SEL_UM_LSB +: 8];
    endfunction

    // Own-agent-only events accept unit mask 00H alone
    function automatic logic self_only(input logic [31:0] sel,
                                       input logic        occ);
        return (sel_umask(sel) == UM_SELF) && occ;
    endfunction

    function automatic logic is_hit_event(input logic [31:0] sel);
        return (sel_code(sel) == EVT_HIT) || (sel_code(sel) == EVT_MODIFIED_HIT_PIN);
    endfunction

    function automatic logic ev_hit(input logic [31:0] sel,
                                    input logic        is_ctr0,
                                    input bfe_ev_t     e);
        logic r;
        r = 1'b0;
        case (sel_code(sel))
            EVT_MEM: begin
                if (sel_umask(sel) == UM_SELF) begin
                    r = e.mem_self;
                end else if (sel_umask(sel) == UM_ANY) begin
                    r = e.mem_any;
                end
            end
            EVT_RCV: begin
                r = self_only(sel, e.rcv);
            end
            EVT_BNR: begin
                r = self_only(sel, e.bnr);
            end
            EVT_HIT: begin
                r = self_only(sel, e.hit);
            end
            EVT_MODIFIED_HIT_PIN: begin
                r = self_only(sel, e.modified_hit_pin);
            end
            EVT_STALL: begin
                r = self_only(sel, e.stall);
            end
            EVT_FP_RETIRED_EVENT: begin
                r = is_ctr0 && self_only(sel, e.fp_retired_event);
            end
            EVT_FPEXE: begin
                r = is_ctr0 && self_only(sel, e.fpexe);
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r && sel[SEL_EN_BIT];
    endfunction

    // Next count and wrap flag for one counter
    function automatic logic [32:0] ctr_step(input logic [31:0] c,
                                             input logic        inc);
        logic [32:0] r;
        r = {1'b0, c};
        if (inc) begin
            // Wrap flag marks the step from all ones to zero
            r[31:0] = c + 32'h0000_0001;
            r[32]   = (c == CTR_MAX);
        end
        return r;
    endfunction

    // Pin indication allowed for this select at the current ratio
    function automatic logic bpm_allowed(input logic [31:0] sel,
                                         input logic        rat_ok);
        return !is_hit_event(sel) || rat_ok;
    endfunction

    // Sticky status: clear first, hardware set wins
    function automatic logic [1:0] sts_next(input logic [1:0] sts,
                                            input logic [1:0] clr,
                                            input logic [1:0] set);
        return (sts & ~clr) | set;
    endfunction

    // Level request from sticky status and enables
    function automatic logic irq_level(input logic [1:0] sts,
                                       input logic [1:0] ien);
        return |(sts & ien);
    endfunction

    function automatic logic [31:0] rd_mux(input bfe_st_t    s,
                                           input logic [4:0] a,
                                           input logic [2:0] rat);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFS_SEL0: begin
                d = s.event_select_zero;
            end
            OFS_SEL1: begin
                d = s.event_select_one;
            end
            OFS_CTR0: begin
                d = s.ctr0;
            end
            OFS_CTR1: begin
                d = s.ctr1;
            end
            OFS_STS: begin
                d = {30'h0000_0000, s.sts};
            end
            OFS_IEN: begin
                d = {30'h0000_0000, s.ien};
            end
            OFS_RATIO: begin
                d = {29'h0000_0000, rat};
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    // ==========================================================
    // Ratio strap synchroniser
    bfe_sync #(
        .W (3)
    ) u_ratio_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (clk_ratio_pin),
        .dout (ratio_sync)
    );

    assign ratio_ok = (ratio_sync == RATIO_2TO1)
                   || (ratio_sync == RATIO_3TO1);

    // ==========================================================
    // Floating-point retirement filter
    // Trapped or assisted ops and loads/stores never reach the count
    assign fp_clean = fp_retire_valid && !fp_retire_trap
                   && !fp_retire_assist && !fp_retire_ldst;

    // ==========================================================
    // Event qualification
    always_comb begin
        ev          = '0;
        ev.mem_self = mem_tran_done && mem_tran_own;
        ev.mem_any  = mem_tran_done;
        ev.rcv      = bus_tick && data_rcv_active;
        ev.bnr      = bus_tick && throttle_drive;
        // Hit drives count stall cycles as well
        ev.hit      = bus_tick && hit_drive;
        ev.modified_hit_pin     = bus_tick && modified_hit_pin_drive;
        ev.stall    = snoop_stall;
        // Assist-handler ops and sub-ops arrive as plain retirements
        ev.fp_retired_event    = fp_clean;
        ev.fpexe    = fp_exec_valid;
    end

    assign inc0 = ev_hit(st_ff.event_select_zero, 1'b1, ev);
    assign inc1 = ev_hit(st_ff.event_select_one, 1'b0, ev);

    // ==========================================================
    // Counter steps
    assign step0 = ctr_step(st_ff.ctr0, inc0);
    assign step1 = ctr_step(st_ff.ctr1, inc1);

    // ==========================================================
    // Status clear mask from a write to the clear register
    assign clr_mask = (reg_wr && reg_addr == OFS_ICLR) ? reg_wdata[1:0]
                                                       : 2'h0;

    // ==========================================================
    // Registers, counters, status
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.ovf   = 2'h0;

        // Counting; a software write to a counter takes priority
        nxt_st.ctr0   = step0[31:0];
        nxt_st.ovf[0] = step0[32];
        nxt_st.ctr1   = step1[31:0];
        nxt_st.ovf[1] = step1[32];

        if (reg_wr) begin
            case (reg_addr)
                OFS_SEL0: begin
                    nxt_st.event_select_zero = reg_wdata;
                end
                OFS_SEL1: begin
                    nxt_st.event_select_one = reg_wdata;
                end
                OFS_CTR0: begin
                    nxt_st.ctr0   = reg_wdata;
                    nxt_st.ovf[0] = 1'b0;
                end
                OFS_CTR1: begin
                    nxt_st.ctr1   = reg_wdata;
                    nxt_st.ovf[1] = 1'b0;
                end
                OFS_IEN: begin
                    nxt_st.ien = reg_wdata[1:0];
                end
                default: begin
                    nxt_st.ien = st_ff.ien;
                end
            endcase
        end

        // Overflow sets win over a clear in the same cycle
        nxt_st.sts = sts_next(st_ff.sts, clr_mask, nxt_st.ovf);

        if (reg_rd) begin
            nxt_st.rdata = rd_mux(st_ff, reg_addr, ratio_sync);
        end

        nxt_st.irq = irq_level(st_ff.sts, st_ff.ien);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff.event_select_zero <= SEL_RST;
            st_ff.event_select_one  <= SEL_RST;
            st_ff.ctr0              <= CTR_RST;
            st_ff.ctr1              <= CTR_RST;
            st_ff.sts               <= FLAGS_RST;
            st_ff.ien               <= FLAGS_RST;
            st_ff.rdata             <= RDATA_RST;
            st_ff.irq               <= IRQ_RST;
            st_ff.ovf               <= FLAGS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Breakpoint-monitor pins
    // Hit events only signal at supported ratios; counting is unaffected
    assign bpm_gate[0] = bpm_allowed(st_ff.event_select_zero,
                                     ratio_ok);
    assign bpm_gate[1] = bpm_allowed(st_ff.event_select_one,
                                     ratio_ok);

    bfe_bpm_pin u_bpm0 (
        .mclk            (mclk),
        .rstn            (rstn),
        .ovf             (st_ff.ovf[0]),
        .pin_control_bit (st_ff.event_select_zero[SEL_PC_BIT]),
        .gate            (bpm_gate[0]),
        .pin             (breakpoint_monitor_pins[0])
    );

    bfe_bpm_pin u_bpm1 (
        .mclk            (mclk),
        .rstn            (rstn),
        .ovf             (st_ff.ovf[1]),
        .pin_control_bit (st_ff.event_select_one[SEL_PC_BIT]),
        .gate            (bpm_gate[1]),
        .pin             (breakpoint_monitor_pins[1])
    );

    // ==========================================================
    // Outputs
    assign reg_rdata = st_ff.rdata;
    assign irq       = st_ff.irq;
endmodule

// [tb/bfe_chk_assertions.sv]
// Port-level assertions for the event counting block
module bfe_chk
    import bfe_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  clk_ratio_pin,
    input wire logic [1:0]  breakpoint_monitor_pins,
    input wire logic        irq
);
    // ==========================================================
    // Shadow of select zero and ratio gating history
    logic [31:0] sh0_ff;
    logic [5:0]  gate_ff;
    logic        hit0;
    logic        bad;
    logic        known;

    assign hit0  = sh0_ff[7:0] == EVT_HIT || sh0_ff[7:0] == EVT_MODIFIED_HIT_PIN;
    assign bad   = clk_ratio_pin != RATIO_2TO1 && clk_ratio_pin != RATIO_3TO1;
    assign known = reg_addr inside {OFS_SEL0, OFS_SEL1, OFS_CTR0, OFS_CTR1,
                                    OFS_STS, OFS_IEN, OFS_RATIO};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sh0_ff  <= SEL_RST;
            gate_ff <= 6'h00;
        end else begin
            if (reg_wr && reg_addr == OFS_SEL0) begin
                sh0_ff <= reg_wdata;
            end
            gate_ff <= {gate_ff[4:0], hit0 && bad && !reg_wr};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Checks
    AST_RESET_QUIET:
        assert property (disable iff (1'b0) !rstn |=>
            breakpoint_monitor_pins == 2'h0 && !irq && reg_rdata == 32'h0)
        else $error("outputs active after reset");
    AST_RD_IDLE:
        assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without a read");
    AST_UNMAPPED:
        assert property (reg_rd && !known |=> reg_rdata == 32'h0)
        else $error("unmapped or clear read not zero");
    AST_STS_UPPER:
        assert property (reg_rd && reg_addr == OFS_STS |=>
            reg_rdata[31:2] == 30'h0)
        else $error("status upper bits set");
    AST_RATIO_UPPER:
        assert property (reg_rd && reg_addr == OFS_RATIO ##1 1'b1 |->
            reg_rdata[31:3] == 29'h0)
        else $error("ratio upper bits set");
    AST_PULSE0:
        assert property ($rose(breakpoint_monitor_pins[0]) &&
            sh0_ff[SEL_PC_BIT] |=> !breakpoint_monitor_pins[0])
        else $error("pulse longer than one cycle");
    AST_TOGGLE0:
        assert property ($rose(breakpoint_monitor_pins[0]) &&
            !sh0_ff[SEL_PC_BIT] |=> breakpoint_monitor_pins[0][*2])
        else $error("toggled level not held");
    AST_GATED0:
        assert property (&gate_ff |-> $stable(breakpoint_monitor_pins[0]))
        else $error("pin moved while gated");
endmodule

// [tb/tb.sv]
// Self-checking bench for the event counting block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bfe_pkg::*;

    logic        mclk;
    logic        rstn;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [12:0] ev;
    logic [2:0]  clk_ratio_pin;
    logic [1:0]  pins;
    logic        irq;
    int          miscompares;
    int          comparisons;
    int          seed;
    int          cyc;
    bit   [31:0] msel [2];
    bit   [31:0] mctr [2];
    bit   [1:0]  msts;
    bit   [1:0]  mien;
    logic [7:0]  codes [8] = '{EVT_MEM, EVT_RCV, EVT_BNR, EVT_HIT,
                               EVT_MODIFIED_HIT_PIN, EVT_STALL, EVT_FP_RETIRED_EVENT, EVT_FPEXE};
    logic [7:0]  ocode [4] = '{EVT_HIT, EVT_HIT, EVT_STALL, EVT_MODIFIED_HIT_PIN};
    logic [2:0]  orat  [4] = '{RATIO_2TO1, 3'h0, 3'h5, RATIO_3TO1};
    int          omode [4] = '{0, 1, 0, 2};

    bfe_event_counting dut (
        .mclk(mclk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bus_tick(ev[0]),
        .mem_tran_done(ev[1]),
        .mem_tran_own(ev[2]),
        .data_rcv_active(ev[3]),
        .throttle_drive(ev[4]),
        .hit_drive(ev[5]),
        .modified_hit_pin_drive(ev[6]),
        .snoop_stall(ev[7]),
        .fp_retire_valid(ev[8]),
        .fp_retire_trap(ev[9]),
        .fp_retire_assist(ev[10]),
        .fp_retire_ldst(ev[11]),
        .fp_exec_valid(ev[12]),
        .clk_ratio_pin(clk_ratio_pin),
        .breakpoint_monitor_pins(pins),
        .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ==========================================================
    // Reference model and bus tasks
    function automatic bit qual(bit [31:0] s, bit c1, bit [12:0] r);
        bit [7:0] um;
        um = s[15:8];
        if (!s[SEL_EN_BIT]) return 1'b0;
        case (s[7:0])
            EVT_MEM:   return r[1] &&
                           (um == UM_ANY || um == UM_SELF && r[2]);
            EVT_RCV:   return um == UM_SELF && r[0] && r[3];
            EVT_BNR:   return um == UM_SELF && r[0] && r[4];
            EVT_HIT:   return um == UM_SELF && r[0] && r[5];
            EVT_MODIFIED_HIT_PIN:  return um == UM_SELF && r[0] && r[6];
            EVT_STALL: return um == UM_SELF && r[7];
            EVT_FP_RETIRED_EVENT: return !c1 && r[8] && r[11:9] == 3'h0;
            EVT_FPEXE: return !c1 && r[12];
            default:   return 1'b0;
        endcase
    endfunction

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        case (a)
            OFS_SEL0: msel[0] = d;
            OFS_SEL1: msel[1] = d;
            OFS_CTR0: mctr[0] = d;
            OFS_CTR1: mctr[1] = d;
            OFS_IEN:  mien = d[1:0];
            OFS_ICLR: msts = msts & ~d[1:0];
            default:  ;
        endcase
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                       input string nm);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(nm, e, reg_rdata);
    endtask

    task automatic run(input int n, input bit [12:0] msk, input bit [12:0] f);
        bit [12:0] r;
        for (int k = 0; k < n; k++) begin
            @(posedge mclk);
            r  = 13'($random(seed)) & msk | f;
            ev <= r;
            for (int c = 0; c < 2; c++) begin
                if (qual(msel[c], c[0], r)) begin
                    if (mctr[c] == 32'hFFFF_FFFF) msts[c] = 1'b1;
                    mctr[c] = mctr[c] + 32'h1;
                end
            end
        end
        @(posedge mclk);
        ev <= 13'h0;
    endtask

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            close_out();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [4:0] a;
        logic [1:0] p0;
        logic [1:0] ep;
        bit   [31:0] s;
        bit         bus;
        rstn = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 13'h0;
        clk_ratio_pin = RATIO_2TO1;
        seed = 38;
        cyc = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            a = 5'(i * 4);
            rdc(a, a == OFS_RATIO ? 32'(RATIO_2TO1) : 32'h0, "reset");
        end
        wr(5'h06, 32'h0040_0061);
        rdc(5'h06, 32'h0, "unmapped");
        rdc(OFS_SEL1, 32'h0, "select one");
        for (int i = 0; i < 8; i++) begin
            bus = codes[i] inside {EVT_RCV, EVT_BNR, EVT_HIT, EVT_MODIFIED_HIT_PIN,
                                   EVT_STALL};
            s = 32'($random(seed));
            wr(OFS_SEL0, 32'h0040_0000 | 32'(codes[i]));
            wr(OFS_SEL1, {9'h0, s[0], 6'h0,
                (bus || codes[i] == EVT_MEM) ? UM_ANY : UM_SELF, codes[i]});
            wr(OFS_CTR0, 32'($random(seed)));
            wr(OFS_CTR1, 32'($random(seed)));
            run(60, 13'h1FFF, 13'h0);
            rdc(OFS_CTR0, mctr[0], "counter zero");
            rdc(OFS_CTR1, mctr[1], "counter one");
            rdc(OFS_SEL1, msel[1], "select one");
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            clk_ratio_pin <= orat[k];
            s = 32'h0040_0000 | 32'(ocode[k]);
            s[SEL_PC_BIT] = omode[k] != 2;
            wr(OFS_IEN, k == 3 ? 32'h0 : 32'h3);
            wr(OFS_SEL0, s);
            wr(OFS_SEL1, s);
            wr(OFS_CTR0, 32'hFFFF_FFFF);
            wr(OFS_CTR1, 32'hFFFF_FFFF);
            rdc(OFS_RATIO, 32'(orat[k]), "ratio");
            p0 = pins;
            run(1, 13'h0, 13'h00E1);
            @(posedge mclk);
            #1;
            ep = omode[k] == 0 ? 2'h3 : omode[k] == 1 ? p0 : ~p0;
            check("pins", 32'(ep), 32'(pins));
            @(posedge mclk);
            #1;
            ep = omode[k] == 0 ? 2'h0 : ep;
            check("pins", 32'(ep), 32'(pins));
            check("irq", 32'(|(msts & mien)), 32'(irq));
            rdc(OFS_STS, 32'(msts), "status");
            wr(OFS_ICLR, 32'h3);
            repeat (2) @(posedge mclk);
            #1;
            check("irq", 32'h0, 32'(irq));
            rdc(OFS_STS, 32'(msts), "status");
        end
        close_out();
    end
endmodule

bind bfe_event_counting bfe_chk u_chk (
    .mclk(mclk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .clk_ratio_pin(clk_ratio_pin),
    .breakpoint_monitor_pins(breakpoint_monitor_pins),
    .irq(irq)
);
